// *** sws_status_regs.sv ***
// Wake, thermal, line fault, reset cause and supply status registers.
// Assumes the serial front end strobes rd_en once per read frame
// after capturing rd_data, and reports events as synchronous levels.
//
// Overview of operation
// - Wake flags latch, clear on read, zero at POR
// - Bus and serial wake flags report wake source
// - Reset pin low clears level selects only
// - Wake input events set bits 0..2
// - Wake event status clears on read
// - Live wake input levels, unlatched
// - Over-temperature latches flag, switches regulator off
// - Aux regulator stays off until re-enable written zero
// - Pre-warning flags follow live condition
// - Aux thermal shutdown also turns battery switch off
// - High line fault code bits
// - High line fault latched, clear on read
// - Low line fault latched, clear on read
// - Reset cause bits, external set with others
// - Reset cause clears on read, POR gives 101
// - Supply status bits
// - Overvoltage live; others latched, clear on read
// - Level selects set wake edge sensitivity
`timescale 1ns/1ps
module sws_status_regs
	import sws_pkg::*;
#(
	parameter int NUM_WAKE = 3
) (
	// Clock and resets
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              rst_pin_low,
	// Register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              rd_en,
	input  wire logic              wr_en,
	input  wire logic [DATA_W-1:0] wr_data,
	output logic      [DATA_W-1:0] rd_data,
	// Detector inputs
	input  wire logic [NUM_WAKE-1:0] wake_in,
	input  wire sws_events_t       ev,
	input  wire logic              aux_on_req,
	input  wire logic              switch_on_req,
	// Power controls
	output logic                   main_regulator_en,
	output logic                   aux_regulator_en,
	output logic                   battery_switch_out_en
);
	initial begin
		if (NUM_WAKE != 3)
			$error("NUM_WAKE must be 3");
	end

	function automatic logic rd_hit(input logic [ADDR_W-1:0] a);
		return rd_en && (addr == a);
	endfunction

	function automatic logic [3:0] rc_next(input logic [3:0] cur, input logic [3:0] set,
			input logic clr);
		// Set wins over clear; unread new events kept
		return (clr ? 4'h0 : cur) | set;
	endfunction

	logic [1:0]          wake_sel_r;
	logic                can_wake_flag_r;
	logic                serial_wake_flag_r;
	logic [NUM_WAKE-1:0] wake_event_r;
	logic [NUM_WAKE-1:0] wake_prev_r;
	logic [NUM_WAKE-1:0] wake_live_r;
	logic                main_sd_r;
	logic                aux_sd_r;
	logic                aux_lock_r;
	logic                main_pw_r;
	logic                aux_pw_r;
	logic [3:0]          high_fault_r;
	logic [3:0]          low_fault_r;
	logic [2:0]          reset_cause_r;
	logic                bat_under_r;
	logic                bat_over_r;
	logic                aux_on_flag_r;
	logic                sw_ot_r;
	logic [NUM_WAKE-1:0] wake_edge;
	logic [DATA_W-1:0]   rd_nxt;

	// Edge detect per selected mode
	always_comb begin
		case (sws_wake_mode_t'(wake_sel_r))
			SWS_WAKE_OFF:  wake_edge = '0;
			SWS_WAKE_RISE: wake_edge = wake_in & ~wake_prev_r;
			SWS_WAKE_FALL: wake_edge = ~wake_in & wake_prev_r;
			SWS_WAKE_BOTH: wake_edge = wake_in ^ wake_prev_r;
			default:       wake_edge = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		wake_prev_r <= wake_in;
		wake_live_r <= wake_in;
	end

	// Level selects: POR and reset pin clear them
	always_ff @(posedge clk) begin
		if (rst || rst_pin_low)
			wake_sel_r <= 2'h0;
		else if (wr_en && addr == ADDR_WAKE_CTL)
			wake_sel_r <= wr_data[WC_SEL_HI:WC_SEL_LO];
	end

	// Wake flags, cleared by POR and on read, not by the reset pin
	always_ff @(posedge clk) begin
		if (rst) begin
			can_wake_flag_r    <= 1'b0;
			serial_wake_flag_r <= 1'b0;
			wake_event_r       <= '0;
		end else begin
			can_wake_flag_r    <= (can_wake_flag_r & ~rd_hit(ADDR_WAKE_CTL)) | ev.can_wake;
			serial_wake_flag_r <= (serial_wake_flag_r & ~rd_hit(ADDR_WAKE_CTL))
				| ev.serial_wake;
			wake_event_r <= (wake_event_r & ~{NUM_WAKE{rd_hit(ADDR_WAKE_EVENT)}})
				| wake_edge;
		end
	end

	// Thermal shutdown and lockout
	always_ff @(posedge clk) begin
		if (rst) begin
			main_sd_r  <= 1'b0;
			aux_sd_r   <= 1'b0;
			aux_lock_r <= 1'b0;
			main_pw_r  <= 1'b0;
			aux_pw_r   <= 1'b0;
		end else begin
			main_sd_r <= (main_sd_r & ~rd_hit(ADDR_OVERTEMP)) | ev.main_ot;
			aux_sd_r  <= (aux_sd_r & ~rd_hit(ADDR_OVERTEMP)) | ev.aux_ot;
			if (ev.aux_ot)
				aux_lock_r <= 1'b1;
			else if (wr_en && addr == ADDR_OVERTEMP && !wr_data[OT_AUX_SD])
				aux_lock_r <= 1'b0;
			main_pw_r <= ev.main_pw;
			aux_pw_r  <= ev.aux_pw;
		end
	end

	// Regulator and switch enables
	always_ff @(posedge clk) begin
		if (rst) begin
			main_regulator_en     <= 1'b0;
			aux_regulator_en      <= 1'b0;
			battery_switch_out_en <= 1'b0;
		end else begin
			main_regulator_en     <= ~ev.main_ot;
			aux_regulator_en      <= aux_on_req & ~ev.aux_ot & ~aux_lock_r;
			battery_switch_out_en <= switch_on_req & ~ev.aux_ot & ~aux_lock_r;
		end
	end

	// Line fault codes
	always_ff @(posedge clk) begin
		if (rst) begin
			high_fault_r <= 4'h0;
			low_fault_r  <= 4'h0;
		end else begin
			high_fault_r <= rc_next(high_fault_r, ev.high_fault, rd_hit(ADDR_HIGH_FAULT));
			low_fault_r  <= rc_next(low_fault_r, ev.low_fault, rd_hit(ADDR_LOW_FAULT));
		end
	end

	// Reset cause; external flag rides with the others
	always_ff @(posedge clk) begin
		if (rst)
			reset_cause_r <= RESET_CAUSE_POR;
		else
			reset_cause_r <= 3'(rc_next({1'b0, reset_cause_r},
				{1'b0, ev.ext_reset | ev.uv_reset | ev.wdog_reset, ev.wdog_reset, ev.uv_reset},
				rd_hit(ADDR_RESET_CAUSE)));
	end

	// Supply status
	always_ff @(posedge clk) begin
		if (rst) begin
			bat_under_r   <= BAT_UNDER_POR;
			bat_over_r    <= 1'b0;
			aux_on_flag_r <= 1'b0;
			sw_ot_r       <= 1'b0;
		end else begin
			bat_under_r   <= (bat_under_r & ~rd_hit(ADDR_SUPPLY)) | ev.bat_under;
			bat_over_r    <= ev.bat_over;
			aux_on_flag_r <= (aux_on_flag_r & ~rd_hit(ADDR_SUPPLY)) | aux_regulator_en;
			sw_ot_r       <= (sw_ot_r & ~rd_hit(ADDR_SUPPLY)) | ev.sw_ot;
		end
	end

	// Read mux
	always_comb begin
		rd_nxt = '0;
		case (addr)
			ADDR_WAKE_CTL:    rd_nxt[3:0] = {serial_wake_flag_r, can_wake_flag_r, wake_sel_r};
			ADDR_WAKE_EVENT:  rd_nxt[NUM_WAKE-1:0] = wake_event_r;
			ADDR_WAKE_LIVE:   rd_nxt[NUM_WAKE-1:0] = wake_live_r;
			ADDR_OVERTEMP:    rd_nxt[3:0] = {aux_pw_r, main_pw_r, aux_sd_r, main_sd_r};
			ADDR_HIGH_FAULT:  rd_nxt[3:0] = high_fault_r;
			ADDR_LOW_FAULT:   rd_nxt[3:0] = low_fault_r;
			ADDR_RESET_CAUSE: rd_nxt[2:0] = reset_cause_r;
			ADDR_SUPPLY:      rd_nxt[3:0] = {sw_ot_r, aux_on_flag_r, bat_over_r, bat_under_r};
			default:          rd_nxt = '0;
		endcase
	end

	// Captured on the read strobe, before the clear takes effect
	always_ff @(posedge clk) begin
		if (rst)
			rd_data <= '0;
		else if (rd_en)
			rd_data <= rd_nxt;
	end
endmodule

// *** sws_pkg.sv ***
// Package for the wake, fault and supply status register bank.
// Assumes a byte-wide serial register port with read and write strobes.
package sws_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	// Register addresses
	localparam logic [5:0] ADDR_WAKE_CTL    = 6'h0c;
	localparam logic [5:0] ADDR_WAKE_EVENT  = 6'h0f;
	localparam logic [5:0] ADDR_WAKE_LIVE   = 6'h11;
	localparam logic [5:0] ADDR_OVERTEMP    = 6'h12;
	localparam logic [5:0] ADDR_HIGH_FAULT  = 6'h14;
	localparam logic [5:0] ADDR_LOW_FAULT   = 6'h17;
	localparam logic [5:0] ADDR_RESET_CAUSE = 6'h18;
	localparam logic [5:0] ADDR_SUPPLY      = 6'h1b;
	// Field positions
	localparam int WC_SEL_LO  = 0;
	localparam int WC_SEL_HI  = 1;
	localparam int WC_CAN_WU  = 2;
	localparam int WC_SER_WU  = 3;
	localparam int OT_MAIN_SD = 0;
	localparam int OT_AUX_SD  = 1;
	localparam int OT_MAIN_PW = 2;
	localparam int OT_AUX_PW  = 3;
	localparam int RC_UNDER   = 0;
	localparam int RC_WDOG    = 1;
	localparam int RC_EXT     = 2;
	localparam int SS_UNDER   = 0;
	localparam int SS_OVER    = 1;
	localparam int SS_AUX_ON  = 2;
	localparam int SS_SW_OT   = 3;
	// Power-on values
	localparam logic [2:0] RESET_CAUSE_POR = 3'h5;
	localparam logic       BAT_UNDER_POR   = 1'h1;
	// Wake edge modes
	typedef enum logic [1:0] {
		SWS_WAKE_OFF  = 2'b00,
		SWS_WAKE_RISE = 2'b01,
		SWS_WAKE_FALL = 2'b10,
		SWS_WAKE_BOTH = 2'b11
	} sws_wake_mode_t;
	// Event inputs from the analog detectors
	typedef struct packed {
		logic       can_wake;
		logic       serial_wake;
		logic       main_ot;
		logic       aux_ot;
		logic       main_pw;
		logic       aux_pw;
		logic [3:0] high_fault;
		logic [3:0] low_fault;
		logic       uv_reset;
		logic       wdog_reset;
		logic       ext_reset;
		logic       bat_under;
		logic       bat_over;
		logic       sw_ot;
	} sws_events_t;
endpackage

// *** sws_status_regs_assertions.sv ***
// Port checker for the status register bank.
// Assumes it is bound into every sws_status_regs instance.
`timescale 1ns/1ps
module sws_chk
	import sws_pkg::*;
#(parameter int NUM_WAKE = 3) (
	// Clock, resets, register port
	input wire logic clk, rst, rst_pin_low, rd_en, wr_en,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data, rd_data,
	// Detectors and power controls
	input wire logic [NUM_WAKE-1:0] wake_in,
	input wire sws_events_t ev,
	input wire logic aux_on_req, switch_on_req, main_regulator_en,
	input wire logic aux_regulator_en, battery_switch_out_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_rd(a); rd_en && addr == a; endsequence
	sequence s_trip; ev.aux_ot; endsequence
	sequence s_hold; !(wr_en && addr == ADDR_OVERTEMP && !wr_data[OT_AUX_SD]) [*4]; endsequence
	property p_ext;
		(ev.uv_reset || ev.wdog_reset) ##[1:2] s_rd(ADDR_RESET_CAUSE) |=> rd_data[RC_EXT];
	endproperty
	property p_clr;
		(rd_en && addr == ADDR_HIGH_FAULT && ev.high_fault == 4'h0) [*2] |=> rd_data == 8'h00;
	endproperty
	a_live_level: assert property (s_rd(ADDR_WAKE_LIVE) |=> rd_data[2:0] == $past(wake_in, 2))
		else $error("live level wrong");
	a_main_ot_off: assert property (ev.main_ot |=> !main_regulator_en)
		else $error("main regulator on");
	a_aux_ot_off: assert property (s_trip |=> !aux_regulator_en && !battery_switch_out_en)
		else $error("aux or switch on");
	a_aux_lock_held: assert property (s_trip ##1 s_hold |=> !aux_regulator_en)
		else $error("aux left lockout");
	a_ext_with_cause: assert property (p_ext)
		else $error("external flag clear");
	a_fault_clear: assert property (p_clr)
		else $error("fault not cleared");
	a_prewarn_live: assert property (s_rd(ADDR_OVERTEMP) |=> rd_data[2] == $past(ev.main_pw, 2))
		else $error("prewarning wrong");
	a_over_live: assert property (s_rd(ADDR_SUPPLY) |=> rd_data[1] == $past(ev.bat_over, 2))
		else $error("overvoltage wrong");
endmodule
bind sws_status_regs sws_chk #(.NUM_WAKE(NUM_WAKE)) u_chk (.*);

// *** sws_host.sv ***
// Host model on the register port of the status bank.
// Assumes rd_data settles on the same edge that samples the strobe.
`timescale 1ns/1ps
module sws_host
	import sws_pkg::*;
(
	// Clock and register port
	input  wire logic              clk,
	output logic      [ADDR_W-1:0] addr,
	output logic                   rd_en,
	output logic                   wr_en,
	output logic      [DATA_W-1:0] wr_data,
	input  wire logic [DATA_W-1:0] rd_data
);
	initial begin
		addr = '0; rd_en = 1'b0; wr_en = 1'b0; wr_data = '0;
	end
	// n above one gives back to back reads
	task automatic rd(input logic [5:0] a, input int n, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		repeat (n) @(posedge clk);
		rd_en <= 1'b0;
		addr <= ~a;
		#1 d = rd_data;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		addr <= ~a;
		wr_data <= ~v;
	endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the status register bank.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module tb_top;
	import sws_pkg::*;
	logic clk = 0, rst = 1, rst_pin_low = 0, aux_on_req = 0, switch_on_req = 0;
	logic [2:0] wake_in = 3'h0;
	sws_events_t ev = '0;
	logic [5:0] addr;
	logic rd_en, wr_en, main_regulator_en, aux_regulator_en, battery_switch_out_en;
	logic [7:0] wr_data, rd_data, d;
	logic [5:0] regs[7] = '{6'h0c, 6'h0f, 6'h11, 6'h12, 6'h14, 6'h17, 6'h1b};
	int miscompares = 0, n_checks = 0;
	initial forever #5 clk = ~clk;
	sws_status_regs DUT (.*);
	sws_host HOST (.clk, .addr, .rd_en, .wr_en, .wr_data, .rd_data);
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rc(input logic [5:0] a, input logic [7:0] e, input int n = 1);
		HOST.rd(a, n, d);
		chk($sformatf("reg %h", a), e, d);
	endtask
	task automatic pe(input sws_events_t e);
		@(posedge clk) ev <= e;
		@(posedge clk) ev <= '0;
	endtask
	task automatic pw(input logic [7:0] e);
		repeat (6) @(posedge clk);
		chk("power", e, {5'h0, main_regulator_en, aux_regulator_en, battery_switch_out_en});
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		test_done;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rc(ADDR_RESET_CAUSE, 8'h05);
		rc(ADDR_SUPPLY, 8'h01);
		foreach (regs[i]) rc(regs[i], 8'h00);
		rc(6'h01, 8'h00);
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			HOST.wr(ADDR_WAKE_CTL, 8'(m));
			rc(ADDR_WAKE_CTL, 8'(m));
			@(posedge clk) wake_in <= 3'h7;
			rc(ADDR_WAKE_EVENT, {5'h0, {3{m[0]}}});
			rc(ADDR_WAKE_LIVE, 8'h07);
			@(posedge clk) wake_in <= 3'h0;
			rc(ADDR_WAKE_EVENT, {5'h0, {3{m[1]}}});
			rc(ADDR_WAKE_EVENT, 8'h00);
		end
		pe('{can_wake: 1'b1, default: '0});
		@(posedge clk) rst_pin_low <= 1'b1;
		@(posedge clk) rst_pin_low <= 1'b0;
		rc(ADDR_WAKE_CTL, 8'h04);
		pe('{serial_wake: 1'b1, default: '0});
		rc(ADDR_WAKE_CTL, 8'h08);
		rc(ADDR_WAKE_CTL, 8'h00);
		$display("test wake done");
		for (int i = 0; i < 4; i++) begin
			pe('{high_fault: 4'(1 << i), low_fault: 4'(1 << i), default: '0});
			rc(ADDR_HIGH_FAULT, 8'(1 << i));
			rc(ADDR_LOW_FAULT, 8'(1 << i));
		end
		pe('{high_fault: 4'h2, default: '0});
		rc(ADDR_HIGH_FAULT, 8'h00, 2);
		HOST.wr(ADDR_HIGH_FAULT, 8'h0f);
		rc(ADDR_HIGH_FAULT, 8'h00);
		pe('{wdog_reset: 1'b1, default: '0});
		rc(ADDR_RESET_CAUSE, 8'h06);
		pe('{ext_reset: 1'b1, default: '0});
		rc(ADDR_RESET_CAUSE, 8'h04);
		$display("test faults done");
		@(posedge clk) {aux_on_req, switch_on_req} <= 2'h3;
		pw(8'h07);
		pe('{aux_ot: 1'b1, default: '0});
		pw(8'h04);
		rc(ADDR_OVERTEMP, 8'h02);
		HOST.wr(ADDR_OVERTEMP, 8'h00);
		pw(8'h07);
		@(posedge clk) ev <= '{main_pw: 1'b1, aux_pw: 1'b1, bat_over: 1'b1, default: '0};
		rc(ADDR_OVERTEMP, 8'h0c, 4);
		rc(ADDR_SUPPLY, 8'h06, 2);
		@(posedge clk) ev <= '0;
		rc(ADDR_OVERTEMP, 8'h00, 4);
		pe('{main_ot: 1'b1, default: '0});
		rc(ADDR_OVERTEMP, 8'h01);
		$display("test thermal done");
		test_done;
	end
endmodule
